// File: src/sers_defines.vh
`ifndef SERS_DEFINES_VH
`define SERS_DEFINES_VH

// clock rate and timing
`define SERS_CLK_MHZ          20
`define SERS_T_WC_MS          5
`define SERS_WC_CYCLES        (`SERS_T_WC_MS * 1000 * `SERS_CLK_MHZ)
`define SERS_POWER_UP_WAIT_US         100
`define SERS_PUP_CYCLES       (`SERS_POWER_UP_WAIT_US * `SERS_CLK_MHZ)

// opcodes, compared after masking the don't-care bit 3
`define SERS_OP_MASK          8'hF7
`define SERS_OP_WREN          8'h06
`define SERS_OP_WRDI          8'h04
`define SERS_OP_RDSR          8'h05
`define SERS_OP_WRSR          8'h01
`define SERS_OP_READ          8'h03
`define SERS_OP_WRITE         8'h02

// status byte field positions
`define SERS_ST_BUSY          0
`define SERS_ST_WEL           1
`define SERS_ST_BP_LO         2
`define SERS_ST_BP_HI         3
`define SERS_ST_PROTECT_PIN_ENABLE          7

// factory and reset values
`define SERS_FACTORY_BYTE     8'hFF
`define SERS_FACTORY_NV       3'h0
`define SERS_RST_WEL          1'b0
`define SERS_RST_BUSY         1'b0
// synchroniser reload: por, cs_n, sck, si low; hold_n, wp_n high (sck matches its idle level)
`define SERS_SYNC_RST         6'h03

`endif

// File: src/sers_sync2.v
`timescale 1ns/1ps
module sers_sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             clk_in,
    input  wire             rstn_in,
    // asynchronous levels in, synchronised levels out
    input  wire [WIDTH-1:0] async_in,
    input  wire [WIDTH-1:0] rst_val_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk_in) begin
        if (!rstn_in) begin
            meta_q <= rst_val_in;
            sync_q <= rst_val_in;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // sers_sync2

// File: src/sers_reset_state.v
`timescale 1ns/1ps
`include "sers_defines.vh"
module sers_reset_state #(
    parameter WC_CYCLES = `SERS_WC_CYCLES
) (
    // clock and reset
    input  wire        clk_in,
    input  wire        rstn_in,
    // power-on detector and factory programming
    input  wire        por_ok_in,
    input  wire        factory_init_in,
    // serial pins
    input  wire        cs_n_in,
    input  wire        sck_in,
    input  wire        si_in,
    input  wire        hold_n_in,
    input  wire        wp_n_in,
    output wire        so_out,
    output wire        so_oe_out,
    // device state
    output wire        standby_out,
    output wire        selected_out,
    output wire        held_out,
    output wire        iface_reset_out,
    // status bits and read address
    output wire        write_enable_latch_out,
    output wire        ready_busy_flag_out,
    output wire        protect_pin_enable_out,
    output wire        block_protect_high_out,
    output wire        block_protect_low_out,
    output wire [15:0] read_addr_out
);

    localparam [7:0] ST_RESET   = 8'h01;
    localparam [7:0] ST_STANDBY = 8'h02;
    localparam [7:0] ST_OPC     = 8'h04;
    localparam [7:0] ST_ADDR    = 8'h08;
    localparam [7:0] ST_READ    = 8'h10;
    localparam [7:0] ST_RDSR    = 8'h20;
    localparam [7:0] ST_WRSR    = 8'h40;
    localparam [7:0] ST_IGNORE  = 8'h80;

    // synchronised pins: por, cs_n, sck, si, hold_n, wp_n
    wire [5:0] pins_s;
    sers_sync2 #(
        .WIDTH (6)
    ) u_sync (
        .clk_in     (clk_in),
        .rstn_in    (rstn_in),
        .async_in   ({por_ok_in, cs_n_in, sck_in, si_in, hold_n_in, wp_n_in}),
        .rst_val_in (`SERS_SYNC_RST),
        .sync_out   (pins_s)
    );

    wire por_s  = pins_s[5];
    wire cs_n_s = pins_s[4];
    wire sck_s  = pins_s[3];
    wire si_s   = pins_s[2];
    wire hold_s = pins_s[1];
    wire wp_s   = pins_s[0];

    reg  [7:0]  state_q;
    reg         cs_prev_q;
    reg         sck_prev_q;
    reg         held_q;
    reg         sck_seen_q;
    reg         ifr_q;
    reg  [7:0]  rx_q;
    reg  [2:0]  bit_q;
    reg         addr_byte_q;
    reg  [15:0] addr_q;
    reg  [7:0]  tx_q;
    reg         so_q;
    reg         oe_q;
    reg         wel_q;
    reg         busy_q;
    reg  [16:0] wc_cnt_q;
    reg  [7:0]  wrsr_data_q;
    reg         wrsr_full_q;
    reg         wrsr_kill_q;
    // nonvolatile: not touched by reset, only by factory init or a status write
    reg  [2:0]  nv_q;

    wire cs_fall  = cs_prev_q & ~cs_n_s;
    wire cs_rise  = ~cs_prev_q & cs_n_s;
    wire sck_rise = ~sck_prev_q & sck_s & ~held_q;
    wire sck_fall = sck_prev_q & ~sck_s & ~held_q;
    wire active   = |(state_q & (ST_OPC | ST_ADDR | ST_READ | ST_RDSR | ST_WRSR | ST_IGNORE));
    wire [7:0] rx_next = {rx_q[6:0], si_s};
    wire [7:0] opcode  = rx_next & `SERS_OP_MASK;
    wire       wp_block = nv_q[2] & ~wp_s;
    wire [7:0] status  = {nv_q[2], 3'h0, nv_q[1], nv_q[0], wel_q, busy_q};

    // nonvolatile protect bits, factory load clears them
    always @(posedge clk_in) begin
        if (factory_init_in) begin
            nv_q <= `SERS_FACTORY_NV;
        end else if (cs_rise && state_q == ST_WRSR && wrsr_full_q && !wrsr_kill_q
                     && wel_q && !busy_q && !held_q) begin
            nv_q <= {wrsr_data_q[`SERS_ST_PROTECT_PIN_ENABLE], wrsr_data_q[`SERS_ST_BP_HI],
                     wrsr_data_q[`SERS_ST_BP_LO]};
        end
    end

    always @(posedge clk_in) begin
        if (!rstn_in) begin
            state_q     <= ST_RESET;
            cs_prev_q   <= 1'b0;
            sck_prev_q  <= 1'b0;
            held_q      <= 1'b0;
            sck_seen_q  <= 1'b0;
            ifr_q       <= 1'b0;
            rx_q        <= 8'h00;
            bit_q       <= 3'h0;
            addr_byte_q <= 1'b0;
            addr_q      <= 16'h0000;
            tx_q        <= 8'h00;
            so_q        <= 1'b0;
            oe_q        <= 1'b0;
            wel_q       <= `SERS_RST_WEL;
            busy_q      <= `SERS_RST_BUSY;
            wc_cnt_q    <= 17'h00000;
            wrsr_data_q <= 8'h00;
            wrsr_full_q <= 1'b0;
            wrsr_kill_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            ifr_q      <= 1'b0;
            // self-timed status write cycle
            if (busy_q) begin
                if (wc_cnt_q == 17'h00001) begin
                    busy_q <= 1'b0;
                    wel_q  <= 1'b0;
                end
                wc_cnt_q <= wc_cnt_q - 17'h00001;
            end
            if (!por_s) begin
                // edge history held low so a select already low never counts
                state_q   <= ST_RESET;
                cs_prev_q <= 1'b0;
                held_q    <= 1'b0;
                oe_q      <= 1'b0;
                wel_q     <= `SERS_RST_WEL;
                busy_q    <= `SERS_RST_BUSY;
                wc_cnt_q  <= 17'h00000;
            end else begin
                cs_prev_q <= cs_n_s;
                case (state_q)
                    ST_RESET: begin
                        state_q <= ST_STANDBY;
                    end
                    ST_STANDBY: begin
                        oe_q <= 1'b0;
                        if (cs_fall) begin
                            state_q    <= ST_OPC;
                            bit_q      <= 3'h0;
                            sck_seen_q <= 1'b0;
                        end
                    end
                    default: begin
                        // hold starts only while sck is low; it ends while sck is low or on deselect
                        if (!sck_s) begin
                            held_q <= ~hold_s;
                        end
                        if (state_q == ST_WRSR && wp_block) begin
                            wrsr_kill_q <= 1'b1;
                        end
                        if (cs_rise) begin
                            state_q     <= ST_STANDBY;
                            oe_q        <= 1'b0;
                            held_q      <= 1'b0;
                            wrsr_full_q <= 1'b0;
                            wrsr_kill_q <= 1'b0;
                            // a select with no clocks is an interface reset
                            ifr_q       <= ~sck_seen_q;
                            if (held_q) begin
                                wel_q <= 1'b0;
                            end else if (state_q == ST_WRSR && wrsr_full_q &&
                                         !wrsr_kill_q && wel_q && !busy_q) begin
                                busy_q   <= 1'b1;
                                wc_cnt_q <= WC_CYCLES[16:0];
                            end
                        end else if (held_q) begin
                            oe_q <= 1'b0;
                        end else begin
                            if (sck_rise) begin
                                sck_seen_q <= 1'b1;
                                rx_q       <= rx_next;
                                bit_q      <= bit_q + 3'h1;
                            end
                            case (state_q)
                                ST_OPC: begin
                                    if (sck_rise && bit_q == 3'h7) begin
                                        if (busy_q && opcode != `SERS_OP_RDSR) begin
                                            state_q <= ST_IGNORE;
                                        end else begin
                                            case (opcode)
                                                `SERS_OP_WREN: begin
                                                    wel_q   <= 1'b1;
                                                    state_q <= ST_IGNORE;
                                                end
                                                `SERS_OP_WRDI: begin
                                                    wel_q   <= 1'b0;
                                                    state_q <= ST_IGNORE;
                                                end
                                                `SERS_OP_RDSR: begin
                                                    tx_q    <= status;
                                                    state_q <= ST_RDSR;
                                                end
                                                `SERS_OP_WRSR: begin
                                                    wrsr_kill_q <= wp_block;
                                                    state_q     <= ST_WRSR;
                                                end
                                                `SERS_OP_READ: begin
                                                    addr_byte_q <= 1'b0;
                                                    state_q     <= ST_ADDR;
                                                end
                                                default: begin
                                                    // array writes live elsewhere
                                                    state_q <= ST_IGNORE;
                                                end
                                            endcase
                                        end
                                    end
                                end
                                ST_ADDR: begin
                                    if (sck_rise && bit_q == 3'h7) begin
                                        addr_q      <= {addr_q[7:0], rx_next};
                                        addr_byte_q <= 1'b1;
                                        if (addr_byte_q) begin
                                            tx_q    <= `SERS_FACTORY_BYTE;
                                            state_q <= ST_READ;
                                        end
                                    end
                                end
                                ST_READ, ST_RDSR: begin
                                    if (sck_fall) begin
                                        so_q <= tx_q[7];
                                        oe_q <= 1'b1;
                                        if (state_q == ST_RDSR) begin
                                            tx_q <= {tx_q[6:0], tx_q[7]};
                                        end else begin
                                            // unwritten array repeats the factory byte
                                            tx_q <= {tx_q[6:0], 1'b1};
                                        end
                                    end
                                    if (sck_rise && bit_q == 3'h7 && state_q == ST_READ) begin
                                        addr_q <= addr_q + 16'h0001;
                                    end
                                    if (sck_rise && bit_q == 3'h7 && state_q == ST_RDSR) begin
                                        tx_q <= status;
                                    end
                                end
                                ST_WRSR: begin
                                    if (sck_rise && bit_q == 3'h7 && !wrsr_full_q) begin
                                        wrsr_data_q <= rx_next;
                                        wrsr_full_q <= 1'b1;
                                    end
                                end
                                default: begin
                                    // invalid or finished opcode: wait for deselect
                                    oe_q <= 1'b0;
                                end
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    assign so_out                 = so_q;
    assign so_oe_out              = oe_q & active & ~held_q & ~cs_n_s;
    assign standby_out            = (state_q == ST_STANDBY);
    assign selected_out           = active;
    assign held_out               = held_q;
    assign iface_reset_out        = ifr_q;
    assign write_enable_latch_out = wel_q;
    assign ready_busy_flag_out    = busy_q;
    assign protect_pin_enable_out = nv_q[2];
    assign block_protect_high_out = nv_q[1];
    assign block_protect_low_out  = nv_q[0];
    assign read_addr_out          = addr_q;

endmodule // sers_reset_state

// File: tb/sers_reset_state_chk.sv
`timescale 1ns/1ps
module sers_reset_state_chk #(
    parameter WC_CYCLES = 50
) (
    // clock and reset
    input wire clk_in,
    input wire rstn_in,
    // watched inputs
    input wire por_ok_in,
    input wire factory_init_in,
    input wire cs_n_in,
    // watched outputs
    input wire standby_out,
    input wire selected_out,
    input wire so_oe_out,
    input wire iface_reset_out,
    input wire write_enable_latch_out,
    input wire ready_busy_flag_out,
    input wire protect_pin_enable_out,
    input wire block_protect_high_out,
    input wire block_protect_low_out
);
    // counts busy cycles so a write time off by one is caught
    reg  [31:0] busy_cnt_q;
    wire [2:0]  nv_bits = {protect_pin_enable_out, block_protect_high_out, block_protect_low_out};
    always @(posedge clk_in) begin
        if (!rstn_in || !ready_busy_flag_out) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_release_clean: assert property ($rose(rstn_in) |-> !write_enable_latch_out
        && !ready_busy_flag_out && $stable(nv_bits)) else $error("dirty state at release");
    a_por_holds: assert property (!por_ok_in [*4] |-> !standby_out && !selected_out)
        else $error("active without supply");
    a_por_standby: assert property ($rose(standby_out) |-> $past(por_ok_in, 2))
        else $error("standby before supply good");
    a_standby_excl: assert property (standby_out |-> !selected_out && !so_oe_out)
        else $error("standby while selected");
    a_desel_hiz: assert property (cs_n_in [*4] |-> !so_oe_out && !selected_out)
        else $error("output driven while deselected");
    a_select_edge: assert property ($rose(selected_out) |-> !cs_n_in && $past(cs_n_in, 5))
        else $error("selected without select fall");
    a_iface_pulse: assert property (iface_reset_out |-> cs_n_in ##1 !iface_reset_out)
        else $error("bad interface reset pulse");
    a_busy_len: assert property ($fell(ready_busy_flag_out) |->
        busy_cnt_q == WC_CYCLES && !write_enable_latch_out) else $error("bad busy length");
    a_factory_zero: assert property (factory_init_in |=> nv_bits == 3'h0)
        else $error("factory bits not zero");
endmodule // sers_reset_state_chk

bind sers_reset_state sers_reset_state_chk #(.WC_CYCLES(WC_CYCLES)) sers_reset_state_chk_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .por_ok_in(por_ok_in),
    .factory_init_in(factory_init_in), .cs_n_in(cs_n_in), .standby_out(standby_out),
    .selected_out(selected_out), .so_oe_out(so_oe_out), .iface_reset_out(iface_reset_out),
    .write_enable_latch_out(write_enable_latch_out), .ready_busy_flag_out(ready_busy_flag_out),
    .protect_pin_enable_out(protect_pin_enable_out),
    .block_protect_high_out(block_protect_high_out),
    .block_protect_low_out(block_protect_low_out));

// File: tb/sers_host.sv
`timescale 1ns/1ps
`include "sers_defines.vh"
module sers_host (
    // clock and serial return
    input  wire clk_in,
    input  wire so_in,
    input  wire so_oe_in,
    // serial pins toward the device
    output reg  cs_n_out,
    output reg  sck_out,
    output reg  si_out
);
    reg       last_q;
    reg [7:0] rx_q;
    event     got;
    // a released line shows the inverse of its last value, so no lucky match
    wire so_line = so_oe_in ? so_in : ~last_q;
    initial begin
        cs_n_out = 1'b0;
        sck_out = 1'b0;
        si_out = 1'b0;
        last_q = 1'b0;
    end
    always @(posedge clk_in) begin
        if (so_oe_in) begin
            last_q <= so_in;
        end
    end
    task clks(input integer n);
        repeat (n) @(negedge clk_in);
    endtask
    task pup_wait;
        clks(`SERS_PUP_CYCLES);
    endtask
    task open_frame;
        cs_n_out = 1'b0;
        clks(4);
    endtask
    task close_frame;
        clks(4);
        cs_n_out = 1'b1;
        clks(8);
    endtask
    // sample late in the high phase: data launched on the fall is still stable there
    task xfer(input [7:0] tx, input chk);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                si_out = tx[i];
                clks(4);
                sck_out = 1'b1;
                clks(4);
                rx_q[i] = so_line;
                sck_out = 1'b0;
            end
            if (chk) begin
                -> got;
            end
        end
    endtask
endmodule // sers_host

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "sers_defines.vh"
module testbench;
    localparam WC = 300;
    localparam LIMIT = 12000;
    reg        clk_in = 1'b0;
    reg        rstn_in = 1'b0;
    reg        por_ok_in = 1'b0;
    reg        factory_init_in = 1'b1;
    // hold pin low through power-up: the device must still not come up held
    reg        hold_n = 1'b0;
    reg [15:0] aexp;
    wire [15:0] raddr;
    reg [31:0] lfsr_q = 32'hE2868A02;
    reg [7:0]  exp_q[$];
    reg [7:0]  val;
    reg        seen;
    integer    err_count = 0;
    integer    compares = 0;
    integer    cyc = 0;
    integer    n;
    wire       cs_n, sck, si, so, so_oe, standby, selected, held, irst;
    wire       write_enable_latch, busy, protect_pin_enable, bph, bpl;
    always #25 clk_in = ~clk_in;
    sers_reset_state #(.WC_CYCLES(WC)) sers_reset_state_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .por_ok_in(por_ok_in),
        .factory_init_in(factory_init_in), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
        .hold_n_in(hold_n), .wp_n_in(1'b1), .so_out(so), .so_oe_out(so_oe),
        .standby_out(standby), .selected_out(selected), .held_out(held),
        .iface_reset_out(irst), .write_enable_latch_out(write_enable_latch), .ready_busy_flag_out(busy),
        .protect_pin_enable_out(protect_pin_enable), .block_protect_high_out(bph),
        .block_protect_low_out(bpl), .read_addr_out(raddr));
    sers_host sers_host_inst (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe),
        .cs_n_out(cs_n), .sck_out(sck), .si_out(si));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task cmp_bit(input got, input exp);
        compares = compares + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task cmp_byte(input [7:0] got, input [7:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one frame: opcode, nw copies of dat, then an optional byte read back
    task frame(input [7:0] op, input integer nw, input [7:0] dat, input rd, input [7:0] exp);
        sers_host_inst.open_frame;
        sers_host_inst.xfer(op, 1'b0);
        repeat (nw) sers_host_inst.xfer(dat, 1'b0);
        if (rd) begin
            exp_q.push_back(exp);
            sers_host_inst.xfer(8'h00, 1'b1);
        end
        sers_host_inst.close_frame;
    endtask
    always @(sers_host_inst.got) cmp_byte(sers_host_inst.rx_q, exp_q.pop_front());
    always @(posedge clk_in) begin
        if (irst === 1'b1) begin
            seen = 1'b1;
        end
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            err_count = err_count + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (2) @(negedge clk_in);
        factory_init_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (10) @(negedge clk_in);
        cmp_bit(standby, 1'b0);
        por_ok_in = 1'b1;
        repeat (6) @(negedge clk_in);
        cmp_bit(standby, 1'b1);
        cmp_bit(selected | held, 1'b0);
        cmp_bit(write_enable_latch | busy, 1'b0);
        hold_n = 1'b1;
        sers_host_inst.close_frame;
        sers_host_inst.pup_wait;
        factory_init_in = 1'b1;
        @(negedge clk_in);
        factory_init_in = 1'b0;
        frame(`SERS_OP_RDSR, 0, 8'h00, 1'b1, 8'h00);
        frame(`SERS_OP_WREN, 0, 8'h00, 1'b0, 8'h00);
        frame(`SERS_OP_RDSR, 0, 8'h00, 1'b1, 8'h02);
        lfsr_q = lfsr(lfsr_q);
        // at least one protect bit set, so the factory load below has to clear something
        val = (lfsr_q[7:0] & 8'h8C) | 8'h04;
        frame(`SERS_OP_WRSR, 1, val, 1'b0, 8'h00);
        frame(`SERS_OP_RDSR, 0, 8'h00, 1'b1, val | 8'h03);
        n = 0;
        while (busy === 1'b1 && n < 1000) begin
            @(negedge clk_in);
            n = n + 1;
        end
        cmp_bit(busy | write_enable_latch, 1'b0);
        frame(`SERS_OP_WREN, 0, 8'h00, 1'b0, 8'h00);
        frame(`SERS_OP_WRDI, 0, 8'h00, 1'b0, 8'h00);
        frame(`SERS_OP_RDSR, 0, 8'h00, 1'b1, val);
        lfsr_q = lfsr(lfsr_q);
        seen = 1'b0;
        frame({4'hF, lfsr_q[3:0]}, 0, 8'h00, 1'b0, 8'h00);
        cmp_bit(seen, 1'b0);
        sers_host_inst.open_frame;
        sers_host_inst.close_frame;
        cmp_bit(seen, 1'b1);
        frame(`SERS_OP_RDSR, 0, 8'h00, 1'b1, val);
        lfsr_q = lfsr(lfsr_q);
        frame(`SERS_OP_READ, 2, lfsr_q[15:8], 1'b1, `SERS_FACTORY_BYTE);
        aexp = {lfsr_q[15:8], lfsr_q[15:8]} + 16'h0001;
        cmp_byte(raddr[15:8], aexp[15:8]);
        cmp_byte(raddr[7:0], aexp[7:0]);
        // supply drops while reset is still released
        por_ok_in = 1'b0;
        repeat (4) @(negedge clk_in);
        cmp_bit(standby | selected, 1'b0);
        rstn_in = 1'b0;
        repeat (4) @(negedge clk_in);
        rstn_in = 1'b1;
        repeat (4) @(negedge clk_in);
        por_ok_in = 1'b1;
        repeat (6) @(negedge clk_in);
        cmp_byte({protect_pin_enable, 4'h0, bph, bpl, write_enable_latch}, {val[7], 4'h0, val[3], val[2], 1'b0});
        cmp_bit(standby, 1'b1);
        frame(`SERS_OP_RDSR, 0, 8'h00, 1'b1, val);
        factory_init_in = 1'b1;
        @(negedge clk_in);
        factory_init_in = 1'b0;
        frame(`SERS_OP_RDSR, 0, 8'h00, 1'b1, 8'h00);
        end_of_test;
    end
endmodule // testbench
